// ### stdc_pkg.sv
package stdc_pkg;

  // ****************************************************************
  // Counter geometry and reset values.
  // ****************************************************************

  // Width of the tick counter and of the reload value.
  localparam int unsigned CNT_W = 24;

  // Counter value after reset.
  localparam logic [23:0] CNT_RST = 24'h000000;

  // Reload value after reset.
  localparam logic [23:0] RELOAD_RST = 24'h000000;

  // Counter value one step above zero, where the interrupt is raised.
  localparam logic [23:0] CNT_ONE = 24'h000001;

  // Amount taken off the counter on each counting edge.
  localparam logic [23:0] CNT_STEP = 24'h000001;

  // ****************************************************************
  // Control/status field positions and reset values.
  // ****************************************************************

  // Bit positions within the control/status word.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_INTEN_BIT  = 1;
  localparam int unsigned CTRL_CLKSRC_BIT = 2;
  localparam int unsigned CTRL_COUNT_BIT  = 16;

  // Width of the control/status word as read by software.
  localparam int unsigned CTRL_W = 17;

  // Control bits after reset: counter disabled, interrupt off.
  localparam logic CTRL_ENABLE_RST = 1'h0;
  localparam logic CTRL_INTEN_RST  = 1'h0;
  localparam logic CTRL_CLKSRC_RST = 1'h0;
  localparam logic COUNT_FLAG_RST  = 1'h0;

  // Counter run states.
  typedef enum logic [1:0] {
    STDC_IDLE,
    STDC_RUN,
    STDC_HALT
  } stdc_state_t;

endpackage

// ### stdc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two flip-flop synchroniser for single-bit levels.
// ****************************************************************
module stdc_sync (
  input  wire logic clk_i,     // Destination clock.
  input  wire logic rst_n_i,   // Active-low asynchronous reset.
  input  wire logic d_i,       // Asynchronous level in.
  output logic      q_o        // Synchronised level out.
);

  logic meta_ff;  // First stage; read only by the second stage.
  logic sync_ff;  // Second stage; safe for logic to read.

  // The first stage may go metastable, so only the second stage reads it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'h0;
      sync_ff <= 1'h0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

`default_nettype wire

// ### stdc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - 24-bit down counter wrapping to reload value.
// - Decrement by one per counting edge when enabled.
// - Edge after zero loads the reload value.
// - Zero reload stops counter at next wrap.
// - Wrap flag set when counter reaches zero.
// - Status read returns flag then clears it.
// - Current-value write clears counter and flag.
// - Current-value write raises no interrupt.
// - Current-value read shows counter this cycle.
// - Counter holds while system clock gated.
// - Counter holds while processor debug-halted.
// - Status gives source, enable, intenable, flag.
module stdc_timer
  import stdc_pkg::*;
(
  input  wire logic              ref_clk_i,         // System clock, 125 MHz.
  input  wire logic              reset_n_i,         // Active-low asynchronous reset.
  input  wire logic              clk_gated_i,       // System clock gated for low power.
  input  wire logic              debug_halt_i,      // Processor halted by debugger (pin).
  input  wire logic              ext_tick_i,        // Alternate counting reference (pin).
  input  wire logic              ctrl_wr_i,         // Write strobe for control bits.
  input  wire logic              ctrl_enable_i,     // Counter enable written value.
  input  wire logic              ctrl_inten_i,      // Interrupt enable written value.
  input  wire logic              ctrl_clksrc_i,     // 1: system clock, 0: reference.
  input  wire logic              ctrl_rd_i,         // Read strobe for control/status.
  input  wire logic              reload_wr_i,       // Write strobe for reload value.
  input  wire logic [CNT_W-1:0]  reload_data_i,     // Reload value written.
  input  wire logic              current_wr_i,      // Write strobe for current value.
  input  wire logic              current_rd_i,      // Read strobe for current value.
  output logic [CTRL_W-1:0]      tick_ctrl_status_o,   // Control/status read data.
  output logic [CNT_W-1:0]       tick_reload_value_o,  // Reload register contents.
  output logic [CNT_W-1:0]       tick_current_value_o, // Counter captured on read.
  output logic                   tick_irq_o            // One-cycle tick interrupt pulse.
);

  // ****************************************************************
  // Reset release and pin synchronisation.
  // ****************************************************************

  logic              rst_meta_ff;   // First reset release stage.
  logic              rst_n_ff;      // Reset used by the whole block.
  logic              halt_s;        // Synchronised debug halt.
  logic              clk_gated_s;   // Synchronised clock gate indication.
  logic              ext_tick_s;    // Synchronised reference clock.
  logic              ext_tick_d_ff; // Previous reference level for edge detect.

  // Reset asserts at once and releases after two edges.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'h0;
      rst_n_ff    <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Halt, gate and reference pins are asynchronous, so each passes two flops.
  // The cost is two to three cycles of latency before the counter reacts.
  stdc_sync u_sync_halt (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_ff),
    .d_i     (debug_halt_i),
    .q_o     (halt_s)
  );

  stdc_sync u_sync_gate (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_ff),
    .d_i     (clk_gated_i),
    .q_o     (clk_gated_s)
  );

  stdc_sync u_sync_ref (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n_ff),
    .d_i     (ext_tick_i),
    .q_o     (ext_tick_s)
  );

  // The edge detector reads only the synchronised copy.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ext_tick_d_ff <= 1'h0;
    end else begin
      ext_tick_d_ff <= ext_tick_s;
    end
  end

  // ****************************************************************
  // Control and reload registers.
  // ****************************************************************

  logic              enable_ff;     // Counter enable.
  logic              inten_ff;      // Tick interrupt enable.
  logic              clksrc_ff;     // Counting clock select.
  logic [CNT_W-1:0]  reload_ff;     // Reload value.

  // Software-written control bits steer the counter.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      enable_ff <= CTRL_ENABLE_RST;
      inten_ff  <= CTRL_INTEN_RST;
      clksrc_ff <= CTRL_CLKSRC_RST;
    end else if (ctrl_wr_i) begin
      enable_ff <= ctrl_enable_i;
      inten_ff  <= ctrl_inten_i;
      clksrc_ff <= ctrl_clksrc_i;
    end
  end

  // Reload value is held until software changes it.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reload_ff <= RELOAD_RST;
    end else if (reload_wr_i) begin
      reload_ff <= reload_data_i;
    end
  end

  // ****************************************************************
  // Counter.
  // ****************************************************************

  stdc_state_t       state_ff;      // Run state of the counter.
  logic [CNT_W-1:0]  count_ff;      // Current counter value.
  logic              count_flag_ff; // Wrap flag, clear on read.
  logic              tick_en;       // One counting edge this cycle.
  logic              hits_zero;     // Counter steps from one to zero.

  // Counting edge: every system clock or a reference rising edge, unless
  // the clock is gated or the core is halted.
  // The reference is sampled by the system clock, so it must stay high and low
  // for at least one system clock each, or some of its edges are lost.
  assign tick_en = enable_ff && !halt_s && !clk_gated_s &&
                   (clksrc_ff || (ext_tick_s && !ext_tick_d_ff));
  assign hits_zero = tick_en && (count_ff == CNT_ONE) && !current_wr_i;

  // State tracks whether the counter is counting, parked, or frozen.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= STDC_IDLE;
    end else begin
      case (state_ff)
        STDC_IDLE: begin
          if (enable_ff && (reload_ff != RELOAD_RST)) begin
            state_ff <= STDC_RUN;
          end
        end
        STDC_RUN: begin
          if (enable_ff && (halt_s || clk_gated_s)) begin
            state_ff <= STDC_HALT;
          end else if (!enable_ff) begin
            state_ff <= STDC_IDLE;
          end
        end
        STDC_HALT: begin
          if (!halt_s && !clk_gated_s) begin
            state_ff <= STDC_RUN;
          end
        end
        default: begin
          state_ff <= STDC_IDLE;
        end
      endcase
    end
  end

  // Counter decrements toward zero, then reloads on the next edge.
  // A zero reload leaves it parked at zero.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      count_ff <= CNT_RST;
    end else if (current_wr_i) begin
      count_ff <= CNT_RST;
    end else if (tick_en) begin
      if (count_ff == CNT_RST) begin
        count_ff <= reload_ff;
      end else begin
        count_ff <= count_ff - CNT_STEP;
      end
    end
  end

  // Flag is set on reaching zero; a new wrap wins over a read clear.
  // A clear that won in the cycle of a wrap would lose that wrap for good,
  // so the set takes priority over the read clear; a current-value write always clears.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      count_flag_ff <= COUNT_FLAG_RST;
    end else if (hits_zero) begin
      count_flag_ff <= 1'h1;
    end else if (ctrl_rd_i || current_wr_i) begin
      count_flag_ff <= 1'h0;
    end
  end

  // ****************************************************************
  // Read data and interrupt.
  // ****************************************************************

  // Status word reports the flag as it stood before the clearing read.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_ctrl_status_o <= '0;
    end else begin
      tick_ctrl_status_o                  <= '0;
      tick_ctrl_status_o[CTRL_ENABLE_BIT] <= enable_ff;
      tick_ctrl_status_o[CTRL_INTEN_BIT]  <= inten_ff;
      tick_ctrl_status_o[CTRL_CLKSRC_BIT] <= clksrc_ff;
      tick_ctrl_status_o[CTRL_COUNT_BIT]  <= count_flag_ff;
    end
  end

  // Reload value is shown from its own register copy.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_reload_value_o <= RELOAD_RST;
    end else begin
      tick_reload_value_o <= reload_ff;
    end
  end

  // The counter is captured in the very cycle of the read strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_current_value_o <= CNT_RST;
    end else if (current_rd_i) begin
      tick_current_value_o <= count_ff;
    end
  end

  // A clearing write never reaches here since hits_zero excludes it.
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_irq_o <= 1'h0;
    end else begin
      tick_irq_o <= hits_zero && inten_ff;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  // Checks stay off until the internal reset copy has released, so no history
  // from inside reset reaches a past or stable value.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_ff);

  a_dec_step: assert property (
    (tick_en && !current_wr_i && count_ff != CNT_RST) |=> count_ff == $past(count_ff) - CNT_STEP)
    else $error("counter did not step down by one");
  a_wrap_load: assert property (
    (tick_en && !current_wr_i && count_ff == CNT_RST) |=> count_ff == $past(reload_ff))
    else $error("counter did not reload after zero");
  a_flag_set: assert property (
    hits_zero |=> count_flag_ff)
    else $error("wrap flag not set at zero");
  a_read_clear: assert property (
    (ctrl_rd_i && !hits_zero) |=> !count_flag_ff ##1 tick_ctrl_status_o[CTRL_COUNT_BIT] == 1'h0)
    else $error("status read did not clear flag");
  a_write_clear: assert property (
    current_wr_i |=> (count_ff == CNT_RST) && !count_flag_ff)
    else $error("current write did not clear");
  a_no_irq_write: assert property (
    current_wr_i |=> !tick_irq_o)
    else $error("clearing write raised interrupt");
  a_read_value: assert property (
    current_rd_i |=> tick_current_value_o == $past(count_ff))
    else $error("read value not from access cycle");
  a_halt_hold: assert property (
    (halt_s && !current_wr_i) |=> $stable(count_ff))
    else $error("counter moved while halted");
  a_gate_hold: assert property (
    (clk_gated_s && !current_wr_i) |=> $stable(count_ff))
    else $error("counter moved while clock gated");
  a_irq_cause: assert property (
    tick_irq_o |-> $past(inten_ff) && $past(count_ff) == CNT_ONE)
    else $error("interrupt without one-to-zero step");
  a_disabled: assert property (
    (!enable_ff && !current_wr_i) |=> $stable(count_ff) && !tick_irq_o)
    else $error("disabled counter changed");
  a_zero_park: assert property (
    (tick_en && !current_wr_i && count_ff == CNT_RST && reload_ff == RELOAD_RST) |=> count_ff == CNT_RST)
    else $error("zero reload did not park counter");
  a_irq_flag: assert property (
    tick_irq_o |-> count_flag_ff)
    else $error("interrupt without wrap flag");

  // Covers show that the main scenarios are reached at all.
  c_wrap_irq:  cover property (hits_zero && inten_ff);
  c_reload:    cover property (tick_en && count_ff == CNT_RST && reload_ff != RELOAD_RST);
  c_halted:    cover property (state_ff == STDC_HALT);
  c_race_flag: cover property (hits_zero && ctrl_rd_i);
  c_ext_count: cover property (tick_en && !clksrc_ff);

endmodule

`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// One comparison: counted always, reported at once on a mismatch.
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (act), (exp)); end end

module tb_top;
  import stdc_pkg::*;

  // ****************************************************************
  // Stimulus, observation and bookkeeping.
  // ****************************************************************
  logic              ref_clk_i, reset_n_i, clk_gated_i, debug_halt_i, ext_tick_i;
  logic              ctrl_wr_i, ctrl_enable_i, ctrl_inten_i, ctrl_clksrc_i, ctrl_rd_i;
  logic              reload_wr_i, current_wr_i, current_rd_i;
  logic [CNT_W-1:0]  reload_data_i;
  logic [CTRL_W-1:0] stat;     // Control/status read data.
  logic [CNT_W-1:0]  rld;      // Reload register copy.
  logic [CNT_W-1:0]  cur;      // Captured counter value.
  logic              irq;      // Tick interrupt pulse.
  int                n_mismatch, total_checks, irq_cnt;

  stdc_timer stdc_timer_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .clk_gated_i(clk_gated_i), .debug_halt_i(debug_halt_i), .ext_tick_i(ext_tick_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_enable_i(ctrl_enable_i), .ctrl_inten_i(ctrl_inten_i),
    .ctrl_clksrc_i(ctrl_clksrc_i), .ctrl_rd_i(ctrl_rd_i), .reload_wr_i(reload_wr_i),
    .reload_data_i(reload_data_i), .current_wr_i(current_wr_i), .current_rd_i(current_rd_i),
    .tick_ctrl_status_o(stat), .tick_reload_value_o(rld), .tick_current_value_o(cur),
    .tick_irq_o(irq));

  // Free-running 125 MHz system clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Count every interrupt pulse, so quiet spans can be judged afterwards.
  always @(posedge ref_clk_i) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // ****************************************************************
  // Shared drivers; each strobe lasts exactly one sampling edge.
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic ctrl_set(input logic en, input logic ie, input logic cs);
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b1; ctrl_enable_i <= en; ctrl_inten_i <= ie; ctrl_clksrc_i <= cs;
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b0;
  endtask

  task automatic reload_set(input logic [CNT_W-1:0] v);
    @(posedge ref_clk_i);
    reload_wr_i <= 1'b1; reload_data_i <= v;
    @(posedge ref_clk_i);
    reload_wr_i <= 1'b0;
  endtask

  task automatic cur_clear();
    @(posedge ref_clk_i);
    current_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    current_wr_i <= 1'b0;
  endtask

  // The captured value is settled just after the edge that took the strobe.
  task automatic rd_cur(output logic [CNT_W-1:0] v);
    @(posedge ref_clk_i);
    current_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    current_rd_i <= 1'b0;
    #1 v = cur;
  endtask

  // Counts edges until the interrupt pulse shows; bounded so a dead timer cannot hang.
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1 n++;
    end while (irq !== 1'b1 && n < 200);
    // A wait that runs out counts as a mismatch.
    `CHK(irq, 1'b1)
  endtask

  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      ext_tick_i <= 1'b1;
      cyc(2);
      @(posedge ref_clk_i);
      ext_tick_i <= 1'b0;
      cyc(2);
    end
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_fields();
    for (int i = 0; i < 8; i++) begin
      ctrl_set(i[0], i[1], i[2]);
      cyc(2);
      #1 `CHK(stat[15:0], {13'h0000, i[2:0]})
    end
  endtask

  // Reload values for the period scenario.
  logic [CNT_W-1:0] v_tab [3] = '{24'h000001, 24'h000003, 24'h000007};

  // Restart from zero, then time the first and the steady wrap periods.
  task automatic t_period();
    int n;
    logic [CNT_W-1:0] v;
    ctrl_set(1'b1, 1'b1, 1'b1);
    foreach (v_tab[k]) begin
      v = v_tab[k];
      reload_set(v);
      cyc(1);
      #1 `CHK(rld, v)
      cur_clear();
      // From a cleared counter: one edge loads the reload, then one per step.
      wait_irq(n);
      `CHK(n, int'(v) + 1)
      @(posedge ref_clk_i);
      #1 `CHK(irq, 1'b0)
      // The period is v + 1 edges; the quiet check above spent one of them.
      wait_irq(n);
      `CHK(n, int'(v))
    end
  endtask

  // The flag survives until read, then a write of the counter clears it early.
  task automatic t_flag();
    int n;
    reload_set(24'h000014);
    wait_irq(n);
    wait_irq(n);
    cyc(5);
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b1)
    @(posedge ref_clk_i);
    ctrl_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    ctrl_rd_i <= 1'b0;
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b1)
    cyc(3);
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b0)
    wait_irq(n);
    cyc(2);
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b1)
    cur_clear();
    cyc(2);
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b0)
    wait_irq(n);
    // Twenty-one edges from the clearing write, two of them spent above.
    `CHK(n, 19)
  endtask

  task automatic t_noint();
    int c0;
    reload_set(24'h000003);
    ctrl_set(1'b1, 1'b0, 1'b1);
    cyc(25);
    c0 = irq_cnt;
    cyc(12);
    `CHK(irq_cnt == c0, 1'b1)
    #1 `CHK(stat[CTRL_COUNT_BIT], 1'b1)
  endtask

  // Kind 0 disables the counter, 1 halts for debug, 2 gates the clock.
  task automatic t_hold(input int kind);
    int c0;
    logic [CNT_W-1:0] a, b;
    ctrl_set(kind != 0, 1'b1, 1'b1);
    if (kind == 1) debug_halt_i <= 1'b1;
    if (kind == 2) clk_gated_i <= 1'b1;
    cyc(6);
    c0 = irq_cnt;
    rd_cur(a);
    cyc(10);
    rd_cur(b);
    `CHK(b, a)
    `CHK(irq_cnt == c0, 1'b1)
    debug_halt_i <= 1'b0;
    clk_gated_i <= 1'b0;
    ctrl_set(1'b1, 1'b1, 1'b1);
    cyc(12);
    `CHK(irq_cnt > c0, 1'b1)
  endtask

  task automatic t_zero();
    int c0;
    logic [CNT_W-1:0] a;
    reload_set(24'h000000);
    cyc(10);
    c0 = irq_cnt;
    cyc(10);
    rd_cur(a);
    `CHK(a, 24'h000000)
    `CHK(irq_cnt == c0, 1'b1)
  endtask

  // Reference edges are the only counting events when the system clock is deselected.
  task automatic t_ext();
    logic [CNT_W-1:0] a, b, c;
    reload_set(24'h000064);
    ctrl_set(1'b1, 1'b0, 1'b0);
    ext_edges(2);
    cyc(4);
    rd_cur(a);
    ext_edges(10);
    cyc(4);
    rd_cur(b);
    `CHK(a - b, 24'h00000A)
    cyc(10);
    rd_cur(c);
    `CHK(c, b)
  endtask

  // ****************************************************************
  // Main sequence, watchdog and verdict.
  // ****************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {reset_n_i, clk_gated_i, debug_halt_i, ext_tick_i, ctrl_wr_i, ctrl_rd_i} = '0;
    {ctrl_enable_i, ctrl_inten_i, ctrl_clksrc_i, reload_wr_i, current_wr_i} = '0;
    {current_rd_i, reload_data_i} = '0;
    {n_mismatch, total_checks, irq_cnt} = '0;
    cyc(10);
    reset_n_i <= 1'b1;
    cyc(3);
    #1 `CHK({stat, rld, cur, irq}, 66'h0)
    t_fields();
    t_period();
    t_flag();
    t_noint();
    for (int k = 0; k < 3; k++) t_hold(k);
    t_zero();
    t_ext();
    give_verdict();
  end

  // The whole run needs about five hundred cycles; this bound only catches a hang.
  initial begin
    cyc(20000);
    n_mismatch++;
    give_verdict();
  end
endmodule

`default_nettype wire
